// ===== bss_code_decode.sv
`timescale 1ns/1ps

module bss_code_decode
  import bss_pkg::*;
(
  input  wire logic [bss_pkg::CODE_W-1:0] code,
  output logic      [11:0]                target_mv
);

  // ****************************************************************
  // Code to target voltage
  // ****************************************************************
  always_comb begin
    if (code[RANGE_BIT]) begin
      target_mv = HIGH_BASE_MV + 12'(code[5:0] * HIGH_STEP_MV);
    end else begin
      target_mv = LOW_BASE_MV + 12'(code[5:0] * LOW_STEP_MV);
    end
  end

endmodule // bss_code_decode

// ===== bss_pkg.sv
package bss_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_NORMAL  = 8'h00;
  localparam logic [7:0] OFF_STANDBY = 8'h04;
  localparam logic [7:0] OFF_SLEEP   = 8'h08;
  localparam logic [7:0] OFF_MODE    = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         CODE_W       = 7;
  localparam int         SETP_W       = 6;
  localparam int         RANGE_BIT    = 6;
  localparam logic [5:0] SETP_RESET   = 6'h00;
  localparam logic [1:0] MODE_RESET   = 2'h0;

  // ****************************************************************
  // Target scale in millivolts
  // ****************************************************************
  localparam logic [11:0] LOW_BASE_MV  = 12'd400;
  localparam logic [11:0] LOW_STEP_MV  = 12'd25;
  localparam logic [11:0] HIGH_BASE_MV = 12'd800;
  localparam logic [11:0] HIGH_STEP_MV = 12'd50;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    BSS_MODE_NORMAL,
    BSS_MODE_STANDBY,
    BSS_MODE_SLEEP
  } bss_mode_t;

endpackage

// ===== bss_setpoint.sv
`timescale 1ns/1ps
// Function
// - Range bit is read-only to the host
// - Range bit comes only from configuration strap
// - Low range: 0.400 to 1.975 V, 25 mV
// - High range: 0.800 to 3.950 V, 50 mV
// - Three independent six-bit set-point fields
// - Initial range bit copied to standby, sleep
// - Code zero is range base, step per count

module bss_setpoint
  import bss_pkg::*;
(
  input  wire logic                       REF_CLK,
  input  wire logic                       ARST_N,
  input  wire logic                       CFG_RANGE_HIGH,
  input  wire logic [7:0]                 S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  output logic [1:0]                      S_AXI_BRESP,
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  input  wire logic [7:0]                 S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  output logic [31:0]                     S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  output logic [bss_pkg::CODE_W-1:0]      ACTIVE_CODE,
  output logic [11:0]                     ACTIVE_TARGET_MV
);
  import bss_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic            range_reg,  range_next;
  logic            loaded_reg, loaded_next;
  logic [5:0]      normal_reg, normal_next;
  logic [5:0]      standby_reg, standby_next;
  logic [5:0]      sleep_reg,  sleep_next;
  bss_mode_t       mode_reg,   mode_next;
  logic            aw_got_reg, aw_got_next;
  logic            w_got_reg,  w_got_next;
  logic [7:0]      awaddr_reg, awaddr_next;
  logic [31:0]     wdata_reg,  wdata_next;
  logic            wstrb0_reg, wstrb0_next;
  logic            bvalid_reg, bvalid_next;
  logic [1:0]      bresp_reg,  bresp_next;
  logic            rvalid_reg, rvalid_next;
  logic [31:0]     rdata_reg,  rdata_next;
  logic [1:0]      rresp_reg,  rresp_next;
  logic            awrdy_reg,  awrdy_next;
  logic            wrdy_reg,   wrdy_next;
  logic            arrdy_reg,  arrdy_next;
  logic [6:0]      code_reg,   code_next;
  logic [11:0]     mv_reg,     mv_next;
  logic [11:0]     dec_mv;
  logic            do_write;
  logic [6:0]      act_code;

  function automatic logic [6:0] full_code(input logic rng, input logic [5:0] sp);
    full_code = {rng, sp};
  endfunction

  bss_code_decode u_dec (
    .code      (act_code),
    .target_mv (dec_mv)
  );

  // ****************************************************************
  // Bus and register next state
  // ****************************************************************
  always_comb begin
    range_next   = range_reg;
    loaded_next  = 1'b1;
    normal_next  = normal_reg;
    standby_next = standby_reg;
    sleep_next   = sleep_reg;
    mode_next    = mode_reg;
    aw_got_next  = aw_got_reg;
    w_got_next   = w_got_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    // The strap is sampled once, on the first edge after reset release.
    if (!loaded_reg) begin
      range_next = CFG_RANGE_HIGH;
    end
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_next  = 1'b1;
      wdata_next  = S_AXI_WDATA;
      wstrb0_next = S_AXI_WSTRB[0];
    end
    do_write = aw_got_reg && w_got_reg && !bvalid_reg;
    if (do_write) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      // Bit 6 of written data is dropped: range never follows the host.
      case (awaddr_reg)
        OFF_NORMAL: begin
          if (wstrb0_reg) normal_next = wdata_reg[5:0];
        end
        OFF_STANDBY: begin
          if (wstrb0_reg) standby_next = wdata_reg[5:0];
        end
        OFF_SLEEP: begin
          if (wstrb0_reg) sleep_next = wdata_reg[5:0];
        end
        OFF_MODE: begin
          if (wstrb0_reg) begin
            case (wdata_reg[1:0])
              2'h1:    mode_next = BSS_MODE_STANDBY;
              2'h2:    mode_next = BSS_MODE_SLEEP;
              default: mode_next = BSS_MODE_NORMAL;
            endcase
          end
        end
        OFF_STATUS: bresp_next = RESP_OKAY;
        default:    bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (S_AXI_ARADDR)
        OFF_NORMAL:  rdata_next = {25'h0, full_code(range_reg, normal_reg)};
        OFF_STANDBY: rdata_next = {25'h0, full_code(range_reg, standby_reg)};
        OFF_SLEEP:   rdata_next = {25'h0, full_code(range_reg, sleep_reg)};
        OFF_MODE:    rdata_next = {30'h0, mode_reg};
        OFF_STATUS:  rdata_next = {8'h0, mv_reg, 5'h0, code_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    // Ready is registered from the next holding state, so it is a flip-flop output.
    awrdy_next = !aw_got_next;
    wrdy_next  = !w_got_next;
    arrdy_next = !rvalid_next;
  end

  // ****************************************************************
  // Active mode code
  // ****************************************************************
  always_comb begin
    case (mode_reg)
      BSS_MODE_STANDBY: act_code = full_code(range_reg, standby_reg);
      BSS_MODE_SLEEP:   act_code = full_code(range_reg, sleep_reg);
      default:          act_code = full_code(range_reg, normal_reg);
    endcase
    code_next = act_code;
    mv_next   = dec_mv;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      range_reg   <= 1'b0;
      loaded_reg  <= 1'b0;
      normal_reg  <= SETP_RESET;
      standby_reg <= SETP_RESET;
      sleep_reg   <= SETP_RESET;
      mode_reg    <= BSS_MODE_NORMAL;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
      awrdy_reg   <= 1'b0;
      wrdy_reg    <= 1'b0;
      arrdy_reg   <= 1'b0;
      code_reg    <= 7'h00;
      mv_reg      <= 12'h000;
    end else begin
      range_reg   <= range_next;
      loaded_reg  <= loaded_next;
      normal_reg  <= normal_next;
      standby_reg <= standby_next;
      sleep_reg   <= sleep_next;
      mode_reg    <= mode_next;
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb0_reg  <= wstrb0_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      awrdy_reg   <= awrdy_next;
      wrdy_reg    <= wrdy_next;
      arrdy_reg   <= arrdy_next;
      code_reg    <= code_next;
      mv_reg      <= mv_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Ready flags are registered; they stay low in reset and while a beat is held.
  assign S_AXI_AWREADY    = awrdy_reg;
  assign S_AXI_WREADY     = wrdy_reg;
  assign S_AXI_BVALID     = bvalid_reg;
  assign S_AXI_BRESP      = bresp_reg;
  assign S_AXI_ARREADY    = arrdy_reg;
  assign S_AXI_RVALID     = rvalid_reg;
  assign S_AXI_RDATA      = rdata_reg;
  assign S_AXI_RRESP      = rresp_reg;
  assign ACTIVE_CODE      = code_reg;
  assign ACTIVE_TARGET_MV = mv_reg;

endmodule // bss_setpoint

// ===== bss_setpoint_monitor.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module bss_monitor
  import bss_pkg::*;
(
  input logic                         REF_CLK,
  input logic                         ARST_N,
  input logic                         CFG_RANGE_HIGH,
  input logic                         S_AXI_BVALID,
  input logic                         S_AXI_BREADY,
  input logic                         S_AXI_RVALID,
  input logic                         S_AXI_RREADY,
  input logic [bss_pkg::CODE_W-1:0]   ACTIVE_CODE,
  input logic [11:0]                  ACTIVE_TARGET_MV
);
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  logic [11:0] sp;
  assign sp = {6'h00, ACTIVE_CODE[5:0]};
  // Saturates so that checks wait until the strap has been loaded.
  always_comb begin
    cnt_next = (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_next;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // The strap may move later; the code must keep the value taken at the first edge.
  a_range_from_strap: assert property (cnt_reg == 3'h3 |-> ACTIVE_CODE[6] == $past(CFG_RANGE_HIGH, 3))
    else $error("range bit differs from strap");
  a_range_stays_fixed: assert property (cnt_reg >= 3'h4 |-> $stable(ACTIVE_CODE[6]))
    else $error("range bit changed");
  a_low_range_scale: assert property (cnt_reg >= 3'h3 && !ACTIVE_CODE[6]
    |-> ACTIVE_TARGET_MV == 12'h190 + 12'h019 * sp)
    else $error("low range target wrong");
  a_high_range_scale: assert property (cnt_reg >= 3'h3 && ACTIVE_CODE[6]
    |-> ACTIVE_TARGET_MV == 12'h320 + 12'h032 * sp)
    else $error("high range target wrong");
  a_zero_code_base: assert property (cnt_reg >= 3'h3 && sp == 12'h000
    |-> ACTIVE_TARGET_MV == (ACTIVE_CODE[6] ? 12'h320 : 12'h190))
    else $error("zero code not at range base");
  a_code_change_cause: assert property (cnt_reg >= 3'h4 && $changed(ACTIVE_CODE)
    |-> S_AXI_BVALID || $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
    else $error("active code changed without a write");
  a_write_answer_ends: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not released");
  a_read_answer_ends: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response not released");
endmodule // bss_monitor

bind bss_setpoint bss_monitor u_mon (
  .REF_CLK          (REF_CLK),
  .ARST_N           (ARST_N),
  .CFG_RANGE_HIGH   (CFG_RANGE_HIGH),
  .S_AXI_BVALID     (S_AXI_BVALID),
  .S_AXI_BREADY     (S_AXI_BREADY),
  .S_AXI_RVALID     (S_AXI_RVALID),
  .S_AXI_RREADY     (S_AXI_RREADY),
  .ACTIVE_CODE      (ACTIVE_CODE),
  .ACTIVE_TARGET_MV (ACTIVE_TARGET_MV)
);

// ===== buck_setpoint_select_tb_top.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module buck_setpoint_select_tb_top;
  import bss_pkg::*;
  typedef struct {
    logic [7:0] wa; logic [31:0] wd; logic [1:0] eb;
    logic [7:0] ra; logic [31:0] er; logic [1:0] ee;
  } bss_row_t;
  logic        clk = 0, rst_n = 0, strap = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [3:0]  wstrb = 4'hf;
  logic        awr, wrdy, bv, arr, rv;
  logic [1:0]  bresp, rresp, resp;
  logic [6:0]  code;
  logic [11:0] mv;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  bss_row_t rows [8] = '{
    '{8'h10, 32'h7f, RESP_OKAY, 8'h00, 32'h0, RESP_OKAY},
    '{8'h00, 32'h7f, RESP_OKAY, 8'h00, 32'h3f, RESP_OKAY},
    '{8'h04, 32'h0c, RESP_OKAY, 8'h00, 32'h3f, RESP_OKAY},
    '{8'h08, 32'h32, RESP_OKAY, 8'h04, 32'h0c, RESP_OKAY},
    '{8'h0c, 32'h01, RESP_OKAY, 8'h10, 32'h2bc00c, RESP_OKAY},
    '{8'h0c, 32'h02, RESP_OKAY, 8'h10, 32'h672032, RESP_OKAY},
    '{8'h0c, 32'h03, RESP_OKAY, 8'h10, 32'h7b703f, RESP_OKAY},
    '{8'h14, 32'h00, RESP_SLVERR, 8'h14, 32'h0, RESP_SLVERR}};
  bss_setpoint dut (.REF_CLK(clk), .ARST_N(rst_n), .CFG_RANGE_HIGH(strap),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .ACTIVE_CODE(code), .ACTIVE_TARGET_MV(mv));
  always #20 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Address and data are offered together; each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    resp = bresp;
    bready <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic s);
    strap <= s; rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    do_reset(1'b0);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      chk({30'h0, resp}, {30'h0, rows[i].eb});
      rd(rows[i].ra);
      chk(got, rows[i].er);
      chk({30'h0, resp}, {30'h0, rows[i].ee});
    end
    $display("table test done");
    wstrb <= 4'h0;
    wr(8'h00, 32'h01);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    wstrb <= 4'hf;
    rd(8'h00);
    chk(got, 32'h3f);
    $display("strobe test done");
    do_reset(1'b1);
    chk({25'h0, code}, 32'h40);
    chk({20'h0, mv}, 32'h320);
    strap <= 1'b0;
    wr(8'h00, 32'h32);
    rd(8'h00);
    chk(got, 32'h72);
    chk({20'h0, mv}, 32'hce4);
    wr(8'h08, 32'h18);
    wr(8'h0c, 32'h2);
    chk({25'h0, code}, 32'h58);
    chk({20'h0, mv}, 32'h7d0);
    $display("high range test done");
    report_and_stop();
  end
endmodule // buck_setpoint_select_tb_top
